// file: rtl/pll_ref_ctrl.sv
// Reference divider, phase detector, lock indicator and pump control top
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module pll_ref_ctrl (
    input  wire logic                      MCLK,
    input  wire logic                      SYS_RST,
    input  wire logic                      HSEL,
    input  wire logic [31:0]               HADDR,
    input  wire logic [1:0]                HTRANS,
    input  wire logic                      HWRITE,
    input  wire logic [2:0]                HSIZE,
    input  wire logic [31:0]               HWDATA,
    input  wire logic                      HREADY,
    output logic      [31:0]               HRDATA,
    output logic                           HREADYOUT,
    output logic                           HRESP,
    input  wire logic                      REF_IN,
    input  wire logic                      FB_IN,
    input  wire logic                      SYNC_IN,
    output logic                           REF_DIV_OUT,
    output logic                           FB_PATH_SEL,
    output logic                           FLAG_OUT,
    output pll_ctrl_pkg::pump_drive_t      PUMP
);
    import pll_ctrl_pkg::*;

    // Configuration registers
    logic [5:0]  ref_div_ratio;
    logic        ref_aligned_mode;
    logic        ref_div_realign_enable;
    logic [1:0]  lock_count_select;
    logic        lock_window_select;
    logic [2:0]  flag_mask;
    pump_cfg_t   pump_cfg;

    // Bus slave: zero wait states, always OKAY
    logic        wr_pend;
    logic [3:0]  wr_idx;
    wire         addr_ok  = HADDR[31:6] == 26'h0 && HADDR[1:0] == 2'b00;
    wire  [3:0]  addr_idx = HADDR[5:2];
    wire         take     = HSEL && HREADY && HTRANS == HTRANS_NONSEQ;
    wire         take_wr  = take && HWRITE && addr_ok;
    wire         take_rd  = take && !HWRITE;

    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            wr_pend <= 1'b0;
            wr_idx  <= 4'h0;
        end else begin
            wr_pend <= take_wr;
            wr_idx  <= addr_idx;
        end
    end

    wire wr_mask = wr_pend && wr_idx == IDX_FLAG_MASK;
    wire wr_loop = wr_pend && wr_idx == IDX_LOOP_CFG;
    wire wr_lock = wr_pend && wr_idx == IDX_LOCK_CFG;
    wire wr_rdiv = wr_pend && wr_idx == IDX_REF_DIV;
    wire wr_pump = wr_pend && wr_idx == IDX_PUMP_CFG;
    wire wr_sync = wr_pend && wr_idx == IDX_SYNC_CFG;

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            ref_div_ratio          <= REF_DIV_RST;
            ref_aligned_mode       <= 1'b0;
            ref_div_realign_enable <= 1'b0;
            lock_count_select      <= LOCK_CFG_RST[1:0];
            lock_window_select     <= LOCK_CFG_RST[2];
            flag_mask              <= FLAG_MASK_RST;
            pump_cfg               <= PUMP_CFG_RST;
        end else begin
            if (wr_mask)
                flag_mask <= HWDATA[2:0];
            if (wr_loop)
                ref_aligned_mode <= HWDATA[0];
            if (wr_lock) begin
                lock_count_select  <= HWDATA[LOCK_SEL_LSB +: 2];
                lock_window_select <= HWDATA[LOCK_WIN_BIT];
            end
            if (wr_rdiv)
                ref_div_ratio <= HWDATA[5:0];
            if (wr_pump)
                pump_cfg <= HWDATA[7:0];
            if (wr_sync)
                ref_div_realign_enable <= HWDATA[0];
        end
    end

    // Status flags
    logic lock;
    logic unlock;
    wire  lock_n = ~lock;
    wire  [2:0] flags = {unlock, lock_n, lock};

    // Read data is captured in the address phase, so it lags status by one
    wire [31:0] rd_word =
        !addr_ok                    ? 32'h0 :
        addr_idx == IDX_STATUS      ? {29'h0, flags} :
        addr_idx == IDX_FLAG_MASK   ? {29'h0, flag_mask} :
        addr_idx == IDX_LOOP_CFG    ? {31'h0, ref_aligned_mode} :
        addr_idx == IDX_LOCK_CFG    ? {29'h0, lock_window_select,
                                       lock_count_select} :
        addr_idx == IDX_REF_DIV     ? {26'h0, ref_div_ratio} :
        addr_idx == IDX_PUMP_CFG    ? {24'h0, pump_cfg} :
        addr_idx == IDX_SYNC_CFG    ? {31'h0, ref_div_realign_enable} :
                                      32'h0;

    always_ff @(posedge MCLK) begin
        if (SYS_RST)
            HRDATA <= 32'h0;
        else if (take_rd)
            HRDATA <= rd_word;
    end

    // Edge detection on the pins; they are synchronous to MCLK
    logic ref_q;
    logic fb_q;
    logic sync_q;
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            ref_q  <= 1'b0;
            fb_q   <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            ref_q  <= REF_IN;
            fb_q   <= FB_IN;
            sync_q <= SYNC_IN;
        end
    end

    wire ref_edge  = REF_IN && !ref_q;
    wire fb_edge   = FB_IN && !fb_q;
    wire sync_rise = SYNC_IN && !sync_q;
    wire realign   = sync_rise && ref_aligned_mode
                     && ref_div_realign_enable
                     && ref_div_ratio >= 6'h02;

    logic r_edge;
    ref_divider u_rdiv (
        .clk      (MCLK),
        .rst      (SYS_RST),
        .ref_edge (ref_edge),
        .ratio    (ref_div_ratio),
        .realign  (realign),
        .div_edge (r_edge)
    );

    // Phase detector: width counts cycles with only one side pending.
    // Window below one MCLK period cannot be resolved at this rate.
    pfd_state_t pfd_state;
    pfd_state_t next_pfd_state;
    logic [7:0] width;
    logic [1:0] ext_cnt;
    wire        pfd_hold = pump_cfg.reset_hiz;
    wire [7:0]  win_cyc  = lock_window_select ? WIN1_CYC : WIN0_CYC;
    wire        cmp_valid = next_pfd_state == PFD_RST
                            && pfd_state != PFD_RST;
    wire        in_window = (pfd_state == PFD_IDLE) || width < win_cyc;

    always_comb begin
        next_pfd_state = pfd_state;
        unique case (pfd_state)
            PFD_IDLE:
                if (r_edge && fb_edge)
                    next_pfd_state = PFD_RST;
                else if (r_edge)
                    next_pfd_state = PFD_UP;
                else if (fb_edge)
                    next_pfd_state = PFD_DN;
            PFD_UP:
                if (fb_edge)
                    next_pfd_state = PFD_RST;
            PFD_DN:
                if (r_edge)
                    next_pfd_state = PFD_RST;
            PFD_RST:
                if (ext_cnt == 2'd0)
                    next_pfd_state = PFD_IDLE;
        endcase
        if (pfd_hold)
            next_pfd_state = PFD_IDLE;
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            pfd_state <= PFD_IDLE;
            width     <= 8'h00;
            ext_cnt   <= 2'd0;
        end else begin
            pfd_state <= next_pfd_state;
            if (next_pfd_state == PFD_IDLE)
                width <= 8'h00;
            else if (width != 8'hFF && next_pfd_state != PFD_RST)
                width <= width + 8'h01;
            if (cmp_valid)
                ext_cnt <= pump_cfg.extend ? PULSE_EXT_CYC : 2'd0;
            else if (ext_cnt != 2'd0)
                ext_cnt <= ext_cnt - 2'd1;
        end
    end

    // comparisons need reference edges, and so do flag updates other than the clear on disable or select change
    lock_detector u_lock (
        .clk       (MCLK),
        .rst       (SYS_RST),
        .cmp_valid (cmp_valid && !pfd_hold),
        .in_window (in_window),
        .count_sel (lock_count_select),
        .lock      (lock),
        .unlock    (unlock)
    );

    // Pump drive; forcing overrides the float so reset can pre-charge
    wire pump_up = pfd_state == PFD_UP;
    wire pump_dn = pfd_state == PFD_DN;
    pump_drive_t next_pump;
    always_comb begin
        next_pump.current = pump_cfg.current;
        next_pump.midrail = pump_cfg.midrail;
        next_pump.extend  = pump_cfg.extend;
        next_pump.source  = pump_cfg.force_source || pump_up;
        next_pump.sink    = pump_cfg.force_sink || pump_dn;
        next_pump.hiz     = pump_cfg.reset_hiz && !pump_cfg.force_source
                            && !pump_cfg.force_sink;
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            PUMP        <= '0;
            FLAG_OUT    <= 1'b0;
            REF_DIV_OUT <= 1'b0;
            FB_PATH_SEL <= 1'b0;
        end else begin
            PUMP        <= next_pump;
            FLAG_OUT    <= |(flags & flag_mask);
            REF_DIV_OUT <= r_edge;
            FB_PATH_SEL <= ref_aligned_mode;
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    sequence hold_seq;
        pump_cfg.reset_hiz ##1 pump_cfg.reset_hiz;
    endsequence

    pfd_quiet_a: assert property (
        hold_seq |-> pfd_state == PFD_IDLE && !cmp_valid)
        else $error("detector active while held in reset");
    force_drive_a: assert property (
        pump_cfg.force_source |=> PUMP.source && !PUMP.hiz)
        else $error("forced source not driven");
    float_pump_a: assert property (
        pump_cfg.reset_hiz && !pump_cfg.force_source
        && !pump_cfg.force_sink |=> PUMP.hiz && !PUMP.source && !PUMP.sink)
        else $error("pump not floated in reset");
    flag_pin_a: assert property (
        ##1 FLAG_OUT == |($past(flags) & $past(flag_mask)))
        else $error("flag pin does not follow mask");
    inv_lock_a: assert property (
        take_rd && addr_idx == IDX_STATUS && addr_ok
        |=> HRDATA[ST_LOCK_N] == !HRDATA[ST_LOCK])
        else $error("inverted lock not complement");
    ratio_write_a: assert property (
        wr_rdiv |=> ref_div_ratio == $past(HWDATA[5:0]))
        else $error("divide ratio write lost");

    sequence wide_reset_seq;
        pfd_state == PFD_RST [*3] ##1 pfd_state == PFD_IDLE;
    endsequence

    // A hold written mid-pulse cuts the widened reset short on purpose
    wide_reset_a: assert property (
        @(posedge MCLK) disable iff (SYS_RST || pfd_hold)
        cmp_valid && pump_cfg.extend |=> wide_reset_seq)
        else $error("widened detector reset has wrong length");
    fb_path_a: assert property (
        ##1 FB_PATH_SEL == $past(ref_aligned_mode))
        else $error("feedback path select does not follow mode");

endmodule : pll_ref_ctrl

// file: rtl/pll_ctrl_pkg.sv
// Shared constants and types for the reference divider and lock control block
package pll_ctrl_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [3:0] IDX_STATUS    = 4'h0;
    localparam logic [3:0] IDX_FLAG_MASK = 4'h1;
    localparam logic [3:0] IDX_LOOP_CFG  = 4'h3;
    localparam logic [3:0] IDX_LOCK_CFG  = 4'h4;
    localparam logic [3:0] IDX_REF_DIV   = 4'h5;
    localparam logic [3:0] IDX_PUMP_CFG  = 4'h7;
    localparam logic [3:0] IDX_SYNC_CFG  = 4'hA;

    // Status bit positions (also the flag mask layout)
    localparam int ST_LOCK   = 0;
    localparam int ST_LOCK_N = 1;
    localparam int ST_UNLOCK = 2;

    // Field positions
    localparam int LOCK_SEL_LSB   = 0;
    localparam int LOCK_WIN_BIT   = 2;
    localparam int PUMP_CUR_LSB   = 0;
    localparam int PUMP_SINK_BIT  = 3;
    localparam int PUMP_SRC_BIT   = 4;
    localparam int PUMP_MID_BIT   = 5;
    localparam int PUMP_RST_BIT   = 6;
    localparam int PUMP_WIDE_BIT  = 7;

    // Reset values
    localparam logic [5:0] REF_DIV_RST   = 6'h01;
    localparam logic [7:0] PUMP_CFG_RST  = 8'h00;
    localparam logic [2:0] LOCK_CFG_RST  = 3'h0;
    localparam logic [2:0] FLAG_MASK_RST = 3'h0;

    // Lock counts per lock_count_select code
    localparam logic [11:0] LOCK_CNT_1 = 12'd32;
    localparam logic [11:0] LOCK_CNT_2 = 12'd256;
    localparam logic [11:0] LOCK_CNT_3 = 12'd2048;

    // Timing: MCLK period and lock window times, in picoseconds
    localparam int CLK_PERIOD_PS = 100000;
    localparam int LOCK_WIN0_PS  = 5000;
    localparam int LOCK_WIN1_PS  = 10700;
    // Longest times round down, never below one cycle
    localparam int WIN0_RAW = LOCK_WIN0_PS / CLK_PERIOD_PS;
    localparam int WIN1_RAW = LOCK_WIN1_PS / CLK_PERIOD_PS;
    localparam logic [7:0] WIN0_CYC = (WIN0_RAW < 1) ? 8'd1 : 8'(WIN0_RAW);
    localparam logic [7:0] WIN1_CYC = (WIN1_RAW < 1) ? 8'd1 : 8'(WIN1_RAW);
    // Extra cycles the detector stays in reset when pulses are widened
    localparam logic [1:0] PULSE_EXT_CYC = 2'd2;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

    typedef struct packed {
        logic       extend;
        logic       reset_hiz;
        logic       midrail;
        logic       force_source;
        logic       force_sink;
        logic [2:0] current;
    } pump_cfg_t;

    typedef struct packed {
        logic       hiz;
        logic       midrail;
        logic       extend;
        logic       source;
        logic       sink;
        logic [2:0] current;
    } pump_drive_t;

    typedef enum logic [3:0] {
        PFD_IDLE = 4'b0001,
        PFD_UP   = 4'b0010,
        PFD_DN   = 4'b0100,
        PFD_RST  = 4'b1000
    } pfd_state_t;

endpackage : pll_ctrl_pkg

// file: rtl/ref_divider.sv
// Six-bit reference divider with realignment
`timescale 1ns/1ps
module ref_divider (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ref_edge,
    input  wire logic [5:0] ratio,
    input  wire logic       realign,
    output logic            div_edge
);
    import pll_ctrl_pkg::*;

    logic [5:0] cnt;
    wire  [5:0] eff_ratio = (ratio == 6'h00) ? 6'h01 : ratio;
    wire        wrap      = ref_edge && (cnt >= eff_ratio - 6'h01);

    // Realign wins: the next full period starts from the next ref edge
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt      <= 6'h00;
            div_edge <= 1'b0;
        end else if (realign) begin
            cnt      <= 6'h00;
            div_edge <= 1'b0;
        end else begin
            div_edge <= wrap;
            if (wrap)
                cnt <= 6'h00;
            else if (ref_edge)
                cnt <= cnt + 6'h01;
        end
    end

    // Independent count of ref edges since the last output or disturbance
    logic [5:0] seen;
    logic [5:0] ratio_q;
    always_ff @(posedge clk) begin
        ratio_q <= ratio;
        if (rst || realign || div_edge || ratio != ratio_q)
            seen <= 6'h00;
        else if (ref_edge)
            seen <= seen + 6'h01;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    div_period_a: assert property (
        ref_edge && !realign && !div_edge && ratio == ratio_q
        && seen == eff_ratio - 6'h01 |=> div_edge)
        else $error("divider missed its output edge");
    realign_hold_a: assert property (
        realign && ratio >= 6'h02 |=> !div_edge ##1 !div_edge)
        else $error("divider edge too soon after realign");

endmodule : ref_divider

// file: rtl/lock_detector.sv
// Lock indicator: counts successive in-window phase comparisons
`timescale 1ns/1ps
module lock_detector (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       cmp_valid,
    input  wire logic       in_window,
    input  wire logic [1:0] count_sel,
    output logic            lock,
    output logic            unlock
);
    import pll_ctrl_pkg::*;

    logic [11:0] run;
    logic [1:0]  sel_q;
    wire         enabled  = (count_sel != 2'd0);
    wire         sel_chg  = (count_sel != sel_q);
    wire [11:0]  target   = (count_sel == 2'd1) ? LOCK_CNT_1 :
                            (count_sel == 2'd2) ? LOCK_CNT_2 : LOCK_CNT_3;
    wire         reached  = (run + 12'd1 >= target);

    always_ff @(posedge clk) begin
        if (rst) begin
            run    <= 12'd0;
            sel_q  <= 2'd0;
            lock   <= 1'b0;
            unlock <= 1'b0;
        end else begin
            sel_q <= count_sel;
            if (!enabled || sel_chg) begin
                run    <= 12'd0;
                lock   <= 1'b0;
                unlock <= 1'b0;
            end else if (cmp_valid && !in_window) begin
                run    <= 12'd0;
                lock   <= 1'b0;
                unlock <= 1'b1;
            end else if (cmp_valid) begin
                unlock <= 1'b0;
                if (reached)
                    lock <= 1'b1;
                if (!lock)
                    run <= run + 12'd1; // saturates once locked
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    unlock_fast_a: assert property (
        cmp_valid && !in_window && enabled && !sel_chg |=> unlock && !lock)
        else $error("out-of-window comparison did not unlock");
    unlock_clear_a: assert property (
        cmp_valid && in_window && enabled && !sel_chg |=> !unlock)
        else $error("unlock not cleared on in-window comparison");
    disabled_idle_a: assert property (
        !enabled |=> !lock && !unlock)
        else $error("flags active while indicator disabled");
    lock_count_a: assert property (
        $rose(lock) |-> $past(run) + 12'd1 >= $past(target))
        else $error("lock declared before the selected count");

endmodule : lock_detector

// file: verif/ref_source.sv
// Reference and feedback edge source facing the block
`timescale 1ns/1ps
module ref_source (
    input  wire logic clk,
    input  wire logic en,
    input  wire logic lag,
    output logic      ref_o,
    output logic      fb_o
);
    logic phase;
    // Edges every other cycle, so each pin has a low cycle between highs
    always_ff @(posedge clk) begin
        if (!en) begin
            phase <= 1'b0;
            ref_o <= 1'b0;
            fb_o  <= 1'b0;
        end else begin
            phase <= ~phase;
            ref_o <= ~phase;
            // The divider output trails the reference pin by one cycle, so
            // aligned feedback does too; lag puts it one cycle early
            fb_o  <= lag ? ~phase : phase;
        end
    end
endmodule : ref_source

// file: verif/pll_ref_ctrl_tb.sv
// Self-checking bench for the reference divider and lock control block
`timescale 1ns/1ps
module pll_ref_ctrl_tb;
    import pll_ctrl_pkg::*;
    logic        mclk    = 1'b0;
    logic        sys_rst = 1'b1;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [2:0]  hsize   = 3'h2;
    logic [31:0] hwdata  = 32'h0;
    logic        sync_in = 1'b0;
    logic        src_en  = 1'b0;
    logic        src_lag = 1'b0;
    logic [31:0] hrdata, rd;
    logic        hreadyout, hresp, ref_in, fb_in;
    logic        div_out, path_sel, flag_out, seen;
    pump_drive_t pump;
    logic [5:0]  ratios [3] = '{6'h01, 6'h02, 6'h3F};
    int          fail_count = 0;
    int          checks_done = 0;
    int          n, l1, need;

    always #50 mclk = ~mclk;

    pll_ref_ctrl u_pll_ref_ctrl (
        .MCLK(mclk), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
        .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .REF_IN(ref_in),
        .FB_IN(fb_in), .SYNC_IN(sync_in), .REF_DIV_OUT(div_out),
        .FB_PATH_SEL(path_sel), .FLAG_OUT(flag_out), .PUMP(pump));

    ref_source u_ref_source (.clk(mclk), .en(src_en), .lag(src_lag),
        .ref_o(ref_in), .fb_o(fb_in));

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic give_up();
        fail_count++;
        $display("CHECK FAILED at %0t: wait bound used up", $time);
        report_and_stop();
    endtask : give_up

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : check

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
    endtask : cyc

    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) give_up();
    endtask : wait_ready

    // Single transfer; the write is in place when this returns
    task automatic bus(input logic wr, input logic [3:0] idx,
                       input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {26'h0, idx, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : bus

    task automatic reg_read(input logic [3:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        check(rd, exp);
    endtask : reg_read

    task automatic wait_div(output int k);
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (div_out !== 1'b1 && k < 600);
        if (div_out !== 1'b1) give_up();
    endtask : wait_div

    // Sync issued at a chosen offset from a divider pulse
    task automatic realign(input int gap, output int lat);
        wait_div(lat);
        wait_div(lat);
        cyc(gap);
        sync_in <= 1'b1;
        @(posedge mclk);
        sync_in <= 1'b0;
        wait_div(lat);
    endtask : realign

    task automatic pump_case(input logic [7:0] cfg, input logic [7:0] exp);
        bus(1'b1, IDX_PUMP_CFG, {24'h0, cfg});
        cyc(2);
        check({24'h0, pump}, {24'h0, exp});
        reg_read(IDX_PUMP_CFG, {24'h0, cfg});
    endtask : pump_case

    initial begin
        #10000000;
        give_up();
    end

    initial begin
        cyc(5);
        sys_rst <= 1'b0;
        @(posedge mclk);
        reg_read(IDX_STATUS, 32'h2);
        reg_read(IDX_REF_DIV, 32'h1);
        reg_read(4'h2, 32'h0);
        check({24'h0, pump}, 32'h0);
        check({31'h0, hresp}, 32'h0);
        bus(1'b1, IDX_FLAG_MASK, 32'h2);
        cyc(3);
        check({31'h0, flag_out}, 32'h1);
        $display("test reset and map done");

        src_en <= 1'b1;
        foreach (ratios[i]) begin
            bus(1'b1, IDX_REF_DIV, {26'h0, ratios[i]});
            wait_div(n);
            wait_div(n);
            wait_div(n);
            check(n, 2 * ratios[i]);
        end
        bus(1'b1, IDX_REF_DIV, 32'h4);
        bus(1'b1, IDX_LOOP_CFG, 32'h1);
        bus(1'b1, IDX_SYNC_CFG, 32'h1);
        check({31'h0, path_sel}, 32'h1);
        realign(2, l1);
        realign(4, n);
        // Without realignment the two latencies differ by two cycles
        check(n, l1);
        bus(1'b1, IDX_LOOP_CFG, 32'h0);
        $display("test divider done");

        bus(1'b1, IDX_REF_DIV, 32'h1);
        bus(1'b1, IDX_PUMP_CFG, 32'h0);
        bus(1'b1, IDX_FLAG_MASK, 32'h1);
        for (int s = 1; s < 4; s++) begin
            bus(1'b1, IDX_LOCK_CFG, 32'(s + 4 * (s % 2)));
            need = (s == 1) ? LOCK_CNT_1 : (s == 2) ? LOCK_CNT_2 : LOCK_CNT_3;
            cyc(2 * (need - 4));
            check({31'h0, flag_out}, 32'h0);
            cyc(20);
            check({31'h0, flag_out}, 32'h1);
        end
        reg_read(IDX_STATUS, 32'h1);
        src_lag <= 1'b1;
        cyc(8);
        reg_read(IDX_STATUS, 32'h6);
        src_lag <= 1'b0;
        cyc(8);
        reg_read(IDX_STATUS, 32'h2);
        bus(1'b1, IDX_LOCK_CFG, 32'h0);
        src_lag <= 1'b1;
        cyc(8);
        reg_read(IDX_STATUS, 32'h2);
        $display("test lock done");

        src_en  <= 1'b0;
        src_lag <= 1'b0;
        for (int i = 0; i < 8; i++) pump_case(8'(i), 8'(i));
        pump_case(8'h17, 8'h17);
        pump_case(8'h0A, 8'h0A);
        pump_case(8'h40, 8'h80);
        pump_case(8'h50, 8'h10);
        pump_case(8'h48, 8'h08);
        pump_case(8'h60, 8'hC0);
        pump_case(8'h83, 8'h23);
        $display("test pump controls done");

        bus(1'b1, IDX_PUMP_CFG, 32'h40);
        src_lag <= 1'b1;
        src_en  <= 1'b1;
        repeat (20) begin
            @(posedge mclk);
            check({30'h0, pump.source, pump.sink}, 32'h0);
        end
        // Widened pulses keep the detector in reset longer, pulses still come
        bus(1'b1, IDX_PUMP_CFG, 32'h80);
        seen = 1'b0;
        repeat (20) begin
            @(posedge mclk);
            seen = seen | pump.source | pump.sink;
        end
        check({31'h0, seen}, 32'h1);
        $display("test detector hold done");
        report_and_stop();
    end
endmodule : pll_ref_ctrl_tb
